// File: verilog/spcs_top.sv
// Summary of operation
// - Transmit store-forward bit blocks cut-through toward port.
// - Receive store-forward bit blocks cut-through from port.
// - Address-off port neither matches nor learns; invalidates.
// - Address-off port reached only by external/flood.
// - All ports address-off: external no-match drops frame.
// - Uplink address-off and unmatched destination drops frame.
// - Width bit selects nibble mode, ports 0-2, 10M.
// - Pacing bit turns transmit pacing on.
// - Force-half-duplex bit actively pulls duplex pin low.
// - Update bit set at reset and pending, cleared done.
// - Update bit maintained only while link is active.
// - Link-down flag reads inverse of link pin.
// - Protocol flag mirrors protocol pin.
// - Speed flag mirrors pin; 10M-only ports read zero.
// - Duplex flag mirrors duplex pin level.
// - Three-bit port state field encodes port condition.
// - Reset puts every port in management-disabled state.
// - Init completion enables management-disabled ports whose disable is clear.
// - Status register is read only.
// - Disable bit latched, set by every reset.
// - Enable write acts only without disable; reads zero.
// - Only enabled state forwards new frames.
// - Link-suspended port re-enables when link returns.
`include "spcs_cfg.svh"
module spcs_top (
	input  wire logic                 ref_clk,
	input  wire logic                 srst,
	input  wire logic                 uplink_strap,
	input  wire logic                 init_done,
	input  wire logic                 dio_wr,
	input  wire logic                 dio_rd,
	input  wire logic [11:0]          dio_addr,
	input  wire logic [7:0]           dio_wdata,
	output logic      [7:0]           dio_rdata,
	output logic                      dio_rvalid,
	input  wire spcs_pkg::spcs_pmask_t port_link_pin,
	input  wire spcs_pkg::spcs_pmask_t port_protocol_pin,
	input  wire spcs_pkg::spcs_pmask_t port_speed_pin,
	input  wire spcs_pkg::spcs_pmask_t port_duplex_pin,
	output spcs_pkg::spcs_pmask_t      port_duplex_out,
	output spcs_pkg::spcs_pmask_t      port_duplex_oe_n,
	output spcs_pkg::spcs_pmask_t      store_forward_tx,
	output spcs_pkg::spcs_pmask_t      store_forward_rx,
	output spcs_pkg::spcs_pmask_t      addr_match_off,
	output spcs_pkg::spcs_pmask_t      tx_pacing_on,
	output spcs_pkg::spcs_pmask_t      force_half_duplex,
	output logic      [2:0]           iface_width_sel,
	output logic      [2:0]           nibble_mode,
	output spcs_pkg::spcs_pmask_t      port_forward_ok,
	output spcs_pkg::spcs_pmask_t      cut_through_tx_ok,
	output spcs_pkg::spcs_pmask_t      cut_through_rx_ok,
	output spcs_pkg::spcs_pmask_t      learn_enable,
	output spcs_pkg::spcs_pmask_t      addr_invalidate,
	input  wire spcs_pkg::spcs_pmask_t addr_dup_evt,
	input  wire spcs_pkg::spcs_pmask_t addr_mis_evt,
	input  wire spcs_pkg::spcs_pmask_t addr_ok_evt,
	input  wire logic                 secure_disable,
	input  wire spcs_pkg::spcs_pmask_t qlen_update_req,
	input  wire spcs_pkg::spcs_pmask_t qlen_update_done,
	input  wire logic                 fwd_req,
	input  wire logic [3:0]           fwd_src,
	input  wire spcs_pkg::spcs_pmask_t int_match_mask,
	input  wire logic                 int_matched,
	input  wire spcs_pkg::spcs_pmask_t external_addr_matcher,
	input  wire logic                 ext_nomatch,
	input  wire spcs_pkg::spcs_pmask_t flood_unknown_fn,
	output logic                      fwd_valid,
	output spcs_pkg::spcs_pmask_t      fwd_mask,
	output logic                      fwd_drop
);
	import spcs_pkg::*;

	// Pins are asynchronous to ref_clk, so each passes two flip-flops.
	spcs_pmask_t link_s1_reg, link_s2_reg, proto_s1_reg, proto_s2_reg;
	spcs_pmask_t speed_s1_reg, speed_s2_reg, dup_s1_reg, dup_s2_reg;
	logic        strap_s1_reg, strap_s2_reg;
	spcs_pmask_t dis_reg, stftx_reg, stfrx_reg, aoff_reg, width_reg, pace_reg, fhd_reg;
	spcs_pmask_t aoff_d_reg, inval_reg, upd_reg;
	spcs_state_t state_reg [`SPCS_NPORTS];
	spcs_pmask_t ctrl_wr, stat_wr, en_st;
	logic [7:0]  rdata_reg;
	logic        rvalid_reg, fvalid_reg, fdrop_reg;
	spcs_pmask_t fmask_reg;

	function automatic logic dio_hit(input logic [11:0] a, input int p, input logic [3:0] off);
		dio_hit = (a[11:8] == `SPCS_DIO_BASE) && (a[7:4] == 4'(p)) && (a[3:0] == off);
	endfunction

	always_ff @(posedge ref_clk) begin
		link_s1_reg  <= port_link_pin;
		link_s2_reg  <= link_s1_reg;
		proto_s1_reg <= port_protocol_pin;
		proto_s2_reg <= proto_s1_reg;
		speed_s1_reg <= port_speed_pin;
		speed_s2_reg <= speed_s1_reg;
		dup_s1_reg   <= port_duplex_pin;
		dup_s2_reg   <= dup_s1_reg;
		strap_s1_reg <= uplink_strap;
		strap_s2_reg <= strap_s1_reg;
	end

	always_comb begin
		for (int p = 0; p < `SPCS_NPORTS; p++) begin
			ctrl_wr[p] = dio_wr && dio_hit(dio_addr, p, `SPCS_OFF_CTRL);
			stat_wr[p] = dio_wr && dio_hit(dio_addr, p, `SPCS_OFF_STAT);
			en_st[p]   = (state_reg[p] == SPCS_EN);
		end
	end

	// Reset values follow the synchronised strap, so the strap must be settled two clocks before srst falls.
	always_ff @(posedge ref_clk) begin
		for (int p = 0; p < `SPCS_NPORTS; p++) begin
			if (srst) begin
				dis_reg[p]   <= `SPCS_RST_DISABLE;
				stftx_reg[p] <= 1'b0;
				stfrx_reg[p] <= ~strap_s2_reg;
				aoff_reg[p]  <= ~strap_s2_reg && (p != 0);
				width_reg[p] <= 1'b0;
				pace_reg[p]  <= 1'b0;
				fhd_reg[p]   <= 1'b0;
			end else if (ctrl_wr[p]) begin
				dis_reg[p]   <= dio_wdata[`SPCS_B_DISABLE];
				stftx_reg[p] <= dio_wdata[`SPCS_B_SFTX];
				stfrx_reg[p] <= dio_wdata[`SPCS_B_SFRX];
				aoff_reg[p]  <= dio_wdata[`SPCS_B_ADDROFF];
				width_reg[p] <= dio_wdata[`SPCS_B_WIDTH] && (p < `SPCS_DUAL_SPEED);
				pace_reg[p]  <= dio_wdata[`SPCS_B_PACE];
				fhd_reg[p]   <= dio_wdata[`SPCS_B_FHD];
			end
		end
	end

	// Port state machine; management writes take priority over hardware events.
	always_ff @(posedge ref_clk) begin
		for (int p = 0; p < `SPCS_NPORTS; p++) begin
			if (srst) begin
				state_reg[p] <= SPCS_MGMT_DIS;
			end else if (ctrl_wr[p] && dio_wdata[`SPCS_B_DISABLE]) begin
				state_reg[p] <= SPCS_MGMT_DIS;
			end else if (ctrl_wr[p] && dio_wdata[`SPCS_B_ENABLE] && state_reg[p] != SPCS_LINK_SUS) begin
				state_reg[p] <= SPCS_EN;
			end else if (init_done && !dis_reg[p] && state_reg[p] == SPCS_MGMT_DIS) begin
				state_reg[p] <= SPCS_EN;
			end else begin
				case (state_reg[p])
					SPCS_EN: begin
						if (!link_s2_reg[p]) begin
							state_reg[p] <= SPCS_LINK_SUS;
						end else if (addr_dup_evt[p]) begin
							state_reg[p] <= secure_disable ? SPCS_DUP_DIS : SPCS_DUP_SUS;
						end else if (addr_mis_evt[p] && p != 0) begin
							state_reg[p] <= secure_disable ? SPCS_MIS_DIS : SPCS_MIS_SUS;
						end
					end
					SPCS_LINK_SUS: begin
						if (link_s2_reg[p]) begin
							state_reg[p] <= SPCS_EN;
						end
					end
					SPCS_DUP_SUS, SPCS_MIS_SUS: begin
						if (addr_ok_evt[p]) begin
							state_reg[p] <= SPCS_EN;
						end
					end
					SPCS_RSVD: begin
						state_reg[p] <= SPCS_MGMT_DIS;
					end
					default: begin
						state_reg[p] <= state_reg[p];
					end
				endcase
			end
		end
	end

	// A new request in the same cycle as completion keeps the bit pending.
	always_ff @(posedge ref_clk) begin
		for (int p = 0; p < `SPCS_NPORTS; p++) begin
			if (srst) begin
				upd_reg[p] <= `SPCS_RST_UPDATE;
			end else if (link_s2_reg[p]) begin
				if (qlen_update_req[p]) begin
					upd_reg[p] <= 1'b1;
				end else if (qlen_update_done[p]) begin
					upd_reg[p] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			// Tracking through reset keeps the reset value of address-off from raising a false invalidate.
			aoff_d_reg <= aoff_reg;
			inval_reg  <= '0;
		end else begin
			aoff_d_reg <= aoff_reg;
			inval_reg  <= aoff_reg & ~aoff_d_reg;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rdata_reg  <= 8'h00;
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= dio_rd;
			rdata_reg  <= 8'h00;
			for (int p = 0; p < `SPCS_NPORTS; p++) begin
				if (dio_rd && dio_hit(dio_addr, p, `SPCS_OFF_CTRL)) begin
					rdata_reg <= {dis_reg[p], 1'b0, stftx_reg[p], stfrx_reg[p],
						aoff_reg[p], width_reg[p], pace_reg[p], fhd_reg[p]};
				end else if (dio_rd && dio_hit(dio_addr, p, `SPCS_OFF_STAT)) begin
					rdata_reg <= {upd_reg[p], ~link_s2_reg[p], proto_s2_reg[p],
						speed_s2_reg[p] && (p < `SPCS_DUAL_SPEED), dup_s2_reg[p], state_reg[p]};
				end
			end
		end
	end

	// Internal matches toward address-off ports are masked; external and flood selections pass.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			fvalid_reg <= 1'b0;
			fmask_reg  <= '0;
			fdrop_reg  <= 1'b0;
		end else begin
			fvalid_reg <= fwd_req;
			if (fwd_req) begin
				if ((&aoff_reg && ext_nomatch) || (aoff_reg[0] && !int_matched)
					|| fwd_src >= 4'(`SPCS_NPORTS) || !en_st[fwd_src]) begin
					fdrop_reg <= 1'b1;
					fmask_reg <= '0;
				end else begin
					fdrop_reg <= 1'b0;
					fmask_reg <= ((int_match_mask & ~aoff_reg) | external_addr_matcher
						| flood_unknown_fn) & en_st;
				end
			end
		end
	end

	assign dio_rdata         = rdata_reg;
	assign dio_rvalid        = rvalid_reg;
	assign port_duplex_out   = '0;
	assign port_duplex_oe_n  = ~fhd_reg;
	assign store_forward_tx  = stftx_reg;
	assign store_forward_rx  = stfrx_reg;
	assign addr_match_off    = aoff_reg;
	assign tx_pacing_on      = pace_reg;
	assign force_half_duplex = fhd_reg;
	assign iface_width_sel   = width_reg[2:0];
	assign nibble_mode       = width_reg[2:0] & ~speed_s2_reg[2:0];
	assign port_forward_ok   = en_st;
	assign cut_through_tx_ok = en_st & ~stftx_reg;
	assign cut_through_rx_ok = en_st & ~stfrx_reg;
	assign learn_enable      = en_st & ~aoff_reg;
	assign addr_invalidate   = inval_reg;
	assign fwd_valid         = fvalid_reg;
	assign fwd_mask          = fmask_reg;
	assign fwd_drop          = fdrop_reg;

	// Per-port checks share one clock and reset.
	for (genvar g = 0; g < `SPCS_NPORTS; g++) begin : g_chk
		property p_rst_state;
			@(posedge ref_clk) srst |=> state_reg[g] == SPCS_MGMT_DIS && dis_reg[g];
		endproperty
		a_rst_state: assert property (p_rst_state) else $error("reset did not disable port");
		property p_stat_ro;
			@(posedge ref_clk) disable iff (srst) stat_wr[g] |=> $stable(dis_reg[g]) && $stable(aoff_reg[g]);
		endproperty
		a_stat_ro: assert property (p_stat_ro) else $error("status write changed control");
		property p_nolink;
			@(posedge ref_clk) disable iff (srst)
				dio_rd && dio_hit(dio_addr, g, `SPCS_OFF_STAT) |=> dio_rdata[6] == !$past(link_s2_reg[g]);
		endproperty
		a_nolink: assert property (p_nolink) else $error("link-down flag wrong");
		property p_en_zero;
			@(posedge ref_clk) disable iff (srst)
				dio_rd && dio_hit(dio_addr, g, `SPCS_OFF_CTRL) |=> !dio_rdata[6];
		endproperty
		a_en_zero: assert property (p_en_zero) else $error("enable bit read nonzero");
		property p_init;
			@(posedge ref_clk) disable iff (srst)
				init_done && !dis_reg[g] && state_reg[g] == SPCS_MGMT_DIS && !ctrl_wr[g] |=> en_st[g];
		endproperty
		a_init: assert property (p_init) else $error("init did not enable port");
		property p_link_back;
			@(posedge ref_clk) disable iff (srst)
				state_reg[g] == SPCS_LINK_SUS && link_s2_reg[g] && !ctrl_wr[g] |=> en_st[g];
		endproperty
		a_link_back: assert property (p_link_back) else $error("port not re-enabled");
		property p_pull;
			@(posedge ref_clk) disable iff (srst) fhd_reg[g] |-> !port_duplex_oe_n[g] && !port_duplex_out[g];
		endproperty
		a_pull: assert property (p_pull) else $error("duplex pin not pulled low");
		property p_block;
			@(posedge ref_clk) disable iff (srst)
				!en_st[g] |-> !cut_through_tx_ok[g] && !learn_enable[g] && !port_forward_ok[g];
		endproperty
		a_block: assert property (p_block) else $error("non-enabled port forwards");
		property p_upd;
			@(posedge ref_clk) disable iff (srst) link_s2_reg[g] && qlen_update_req[g] |=> upd_reg[g];
		endproperty
		a_upd: assert property (p_upd) else $error("update pending lost");
		property p_upd_frozen;
			@(posedge ref_clk) disable iff (srst) !link_s2_reg[g] |=> $stable(upd_reg[g]);
		endproperty
		a_upd_frozen: assert property (p_upd_frozen) else $error("update bit changed without link");
	end

	property p_uplink_drop;
		@(posedge ref_clk) disable iff (srst) fwd_req && aoff_reg[0] && !int_matched |=> fwd_drop && fwd_valid;
	endproperty
	a_uplink_drop: assert property (p_uplink_drop) else $error("unmatched uplink frame kept");
	property p_all_off_drop;
		@(posedge ref_clk) disable iff (srst) fwd_req && &aoff_reg && ext_nomatch |=> fwd_drop && fwd_valid;
	endproperty
	a_all_off_drop: assert property (p_all_off_drop) else $error("external no-match frame kept");
	property p_uplink_no_mis;
		@(posedge ref_clk) disable iff (srst) state_reg[0] != SPCS_MIS_SUS && state_reg[0] != SPCS_MIS_DIS;
	endproperty
	a_uplink_no_mis: assert property (p_uplink_no_mis) else $error("uplink entered mismatch state");

	property p_c_init;
		@(posedge ref_clk) disable iff (srst) init_done ##1 en_st[1];
	endproperty
	c_init: cover property (p_c_init);
	property p_c_susp;
		@(posedge ref_clk) disable iff (srst) state_reg[1] == SPCS_LINK_SUS ##[1:20] en_st[1];
	endproperty
	c_susp: cover property (p_c_susp);
	property p_c_drop;
		@(posedge ref_clk) disable iff (srst) fwd_valid && fwd_drop;
	endproperty
	c_drop: cover property (p_c_drop);
	property p_c_mis;
		@(posedge ref_clk) disable iff (srst) addr_mis_evt[3] ##1 state_reg[3] == SPCS_MIS_DIS;
	endproperty
	c_mis: cover property (p_c_mis);
endmodule

// File: verilog/spcs_cfg.svh
`ifndef SPCS_CFG_SVH
`define SPCS_CFG_SVH
`define SPCS_NPORTS        15
`define SPCS_DUAL_SPEED    3
`define SPCS_DIO_BASE      4'h8
`define SPCS_OFF_CTRL      4'h0
`define SPCS_OFF_STAT      4'h1
`define SPCS_B_DISABLE     7
`define SPCS_B_ENABLE      6
`define SPCS_B_SFTX        5
`define SPCS_B_SFRX        4
`define SPCS_B_ADDROFF     3
`define SPCS_B_WIDTH       2
`define SPCS_B_PACE        1
`define SPCS_B_FHD         0
`define SPCS_B_UPDATE      7
`define SPCS_B_NOLINK      6
`define SPCS_B_PROTO       5
`define SPCS_B_SPEED       4
`define SPCS_B_DUPLEX      3
`define SPCS_RST_DISABLE   1'b1
`define SPCS_RST_UPDATE    1'b1
`endif

// File: verilog/spcs_pkg.sv
package spcs_pkg;
	typedef enum logic [2:0] {
		SPCS_EN       = 3'b000,
		SPCS_LINK_SUS = 3'b001,
		SPCS_DUP_SUS  = 3'b010,
		SPCS_MIS_SUS  = 3'b011,
		SPCS_MGMT_DIS = 3'b100,
		SPCS_RSVD     = 3'b101,
		SPCS_DUP_DIS  = 3'b110,
		SPCS_MIS_DIS  = 3'b111
	} spcs_state_t;
	typedef logic [14:0] spcs_pmask_t;
endpackage

// File: tb/spcs_phy_model.sv
module spcs_phy_model (
	input  wire spcs_pkg::spcs_pmask_t link_set,
	input  wire spcs_pkg::spcs_pmask_t speed_set,
	input  wire spcs_pkg::spcs_pmask_t duplex_out,
	input  wire spcs_pkg::spcs_pmask_t duplex_oe_n,
	output spcs_pkg::spcs_pmask_t      link_pin,
	output spcs_pkg::spcs_pmask_t      protocol_pin,
	output spcs_pkg::spcs_pmask_t      speed_pin,
	output spcs_pkg::spcs_pmask_t      duplex_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	import spcs_pkg::*;
	// Only the uplink runs the streaming protocol, every other port is strapped low.
	assign protocol_pin = 15'h0001;
	assign link_pin     = link_set;
	assign speed_pin    = speed_set;
	// The PHY reports full duplex, but a switch pin that drives the wire wins over it.
	assign duplex_pin   = (duplex_out & ~duplex_oe_n) | duplex_oe_n;
endmodule

// File: tb/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import spcs_pkg::*;
	typedef struct {logic [11:0] a; logic [7:0] d; logic [7:0] e;} spcs_row_t;
	logic        ref_clk   = 1'b0;
	logic        srst      = 1'b1;
	logic        init_done = 1'b0;
	logic        dio_wr    = 1'b0;
	logic        dio_rd    = 1'b0;
	logic [11:0] dio_addr  = 12'h000;
	logic [7:0]  dio_wdata = 8'h00;
	logic        sec_dis   = 1'b0;
	logic        fwd_req   = 1'b0;
	logic        matched   = 1'b0;
	logic        nomatch   = 1'b0;
	logic [3:0]  fwd_src   = 4'h0;
	logic [7:0]  dio_rdata;
	logic [2:0]  wsel;
	logic [2:0]  nib;
	logic        dio_rvalid;
	logic        fwd_valid;
	logic        fwd_drop;
	logic        saw;
	spcs_pmask_t link_set = 15'h7FFF;
	spcs_pmask_t speed_set = 15'h0000;
	spcs_pmask_t dup_e = 15'h0000;
	spcs_pmask_t ok_e = 15'h0000;
	spcs_pmask_t q_req = 15'h0000;
	spcs_pmask_t q_done = 15'h0000;
	spcs_pmask_t em = 15'h0000;
	spcs_pmask_t fl = 15'h0000;
	spcs_pmask_t mis_e = 15'h0000;
	spcs_pmask_t lk, pr, sp, dp, d_out, d_oe_n, sf_tx, sf_rx, a_off, pace, fhd, fok, inval, fmask;
	spcs_pmask_t ctx, crx, lrn;
	int          miscompares = 0;
	int          checked = 0;
	spcs_row_t   rows [7] = '{'{12'h820, 8'hFF, 8'hBF}, '{12'h821, 8'h00, 8'h84}, '{12'h830, 8'h3F, 8'h3B},
		'{12'h830, 8'h40, 8'h00}, '{12'h831, 8'h55, 8'h88}, '{12'h8F0, 8'h40, 8'h00}, '{12'h900, 8'h40, 8'h00}};

	spcs_top spcs_top_inst (.ref_clk(ref_clk), .srst(srst), .uplink_strap(1'b0), .init_done(init_done),
		.dio_wr(dio_wr), .dio_rd(dio_rd), .dio_addr(dio_addr), .dio_wdata(dio_wdata), .dio_rdata(dio_rdata),
		.dio_rvalid(dio_rvalid), .port_link_pin(lk), .port_protocol_pin(pr), .port_speed_pin(sp),
		.port_duplex_pin(dp), .port_duplex_out(d_out), .port_duplex_oe_n(d_oe_n), .store_forward_tx(sf_tx),
		.store_forward_rx(sf_rx), .addr_match_off(a_off), .tx_pacing_on(pace), .force_half_duplex(fhd),
		.iface_width_sel(wsel), .nibble_mode(nib), .port_forward_ok(fok), .cut_through_tx_ok(ctx),
		.cut_through_rx_ok(crx), .learn_enable(lrn), .addr_invalidate(inval), .addr_dup_evt(dup_e),
		.addr_mis_evt(mis_e), .addr_ok_evt(ok_e), .secure_disable(sec_dis), .qlen_update_req(q_req),
		.qlen_update_done(q_done), .fwd_req(fwd_req), .fwd_src(fwd_src), .int_match_mask(15'h7FFF),
		.int_matched(matched), .external_addr_matcher(em), .ext_nomatch(nomatch), .flood_unknown_fn(fl),
		.fwd_valid(fwd_valid), .fwd_mask(fmask), .fwd_drop(fwd_drop));

	spcs_phy_model spcs_phy_model_inst (.link_set(link_set), .speed_set(speed_set), .duplex_out(d_out),
		.duplex_oe_n(d_oe_n), .link_pin(lk), .protocol_pin(pr), .speed_pin(sp), .duplex_pin(dp));

	always #2.5 ref_clk = ~ref_clk;

	task automatic chk(input logic [14:0] got, input logic [14:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		dio_wr <= 1'b1;
		dio_addr <= a;
		dio_wdata <= d;
		@(posedge ref_clk);
		dio_wr <= 1'b0;
		@(negedge ref_clk);
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		dio_rd <= 1'b1;
		dio_addr <= a;
		@(posedge ref_clk);
		dio_rd <= 1'b0;
		@(negedge ref_clk);
		chk({6'h00, dio_rvalid, dio_rdata}, {7'h01, e});
	endtask

	task automatic fwd(input logic [3:0] s, input logic m, input spcs_pmask_t x, input spcs_pmask_t e, input logic d);
		@(posedge ref_clk);
		fwd_req <= 1'b1;
		fwd_src <= s;
		matched <= m;
		em <= x;
		@(posedge ref_clk);
		fwd_req <= 1'b0;
		@(negedge ref_clk);
		chk({13'h0000, fwd_valid, fwd_drop}, {13'h0000, 1'b1, d});
		if (!d) chk(fmask, e);
	endtask

	task automatic give_verdict;
		if (miscompares == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge ref_clk);
		miscompares++;
		give_verdict();
	end

	initial begin
		repeat (5) @(posedge ref_clk);
		srst <= 1'b0;
		rd(12'h800, 8'h90);
		rd(12'h810, 8'h98);
		rd(12'h801, 8'hAC);
		chk(fok, 15'h0000);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].e);
		end
		wr(12'h840, 8'h3F);
		chk({9'h000, sf_tx[4], sf_rx[4], a_off[4], pace[4], fhd[4], d_oe_n[4]}, 15'h003E);
		wr(12'h800, 8'h48);
		saw = 1'b0;
		repeat (3) @(negedge ref_clk) saw |= inval[0];
		chk({14'h0000, saw}, 15'h0001);
		rd(12'h841, 8'h84);
		wr(12'h810, 8'h04);
		chk({9'h000, wsel, nib}, 15'h0036);
		@(posedge ref_clk) speed_set <= 15'h0022;
		repeat (6) @(negedge ref_clk);
		chk({9'h000, wsel, nib}, 15'h0034);
		rd(12'h851, 8'h8C);
		// Clearing the disable bit alone must not move the port until init completes.
		wr(12'h860, 8'h00);
		chk(fok, 15'h0009);
		@(posedge ref_clk) init_done <= 1'b1;
		@(posedge ref_clk) init_done <= 1'b0;
		@(negedge ref_clk);
		chk(fok, 15'h005B);
		chk(ctx, 15'h004B);
		chk(crx, 15'h004B);
		chk(lrn, 15'h004A);
		@(posedge ref_clk) link_set[6] <= 1'b0;
		repeat (6) @(negedge ref_clk);
		chk(fok, 15'h001B);
		@(posedge ref_clk) q_done <= 15'h0040;
		@(posedge ref_clk) q_done <= 15'h0000;
		rd(12'h861, 8'hC9);
		@(posedge ref_clk) link_set[6] <= 1'b1;
		repeat (6) @(negedge ref_clk);
		chk(fok, 15'h005B);
		@(posedge ref_clk) q_done <= 15'h0040;
		@(posedge ref_clk) q_done <= 15'h0000;
		rd(12'h861, 8'h08);
		@(posedge ref_clk) q_req <= 15'h0040;
		@(posedge ref_clk) q_req <= 15'h0000;
		rd(12'h861, 8'h88);
		fwd(4'h6, 1'b1, 15'h0000, 15'h004A, 1'b0);
		fwd(4'h6, 1'b0, 15'h0000, 15'h0000, 1'b1);
		fwd(4'h6, 1'b1, 15'h0011, 15'h005B, 1'b0);
		fwd(4'h2, 1'b1, 15'h0000, 15'h0000, 1'b1);
		@(posedge ref_clk) dup_e <= 15'h0008;
		@(posedge ref_clk) dup_e <= 15'h0000;
		rd(12'h831, 8'h8A);
		@(posedge ref_clk) ok_e <= 15'h0008;
		@(posedge ref_clk) ok_e <= 15'h0000;
		rd(12'h831, 8'h88);
		@(posedge ref_clk) sec_dis <= 1'b1;
		@(posedge ref_clk) dup_e <= 15'h0008;
		@(posedge ref_clk) dup_e <= 15'h0000;
		rd(12'h831, 8'h8E);
		wr(12'h830, 8'h40);
		rd(12'h831, 8'h88);
		@(posedge ref_clk) mis_e <= 15'h0009;
		@(posedge ref_clk) mis_e <= 15'h0000;
		rd(12'h831, 8'h8F);
		chk(fok, 15'h0053);
		@(posedge ref_clk) srst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		@(negedge ref_clk);
		chk(fok, 15'h0000);
		rd(12'h830, 8'h98);
		wr(12'h800, 8'h48);
		@(posedge ref_clk) nomatch <= 1'b1;
		fwd(4'h0, 1'b1, 15'h0001, 15'h0000, 1'b1);
		@(posedge ref_clk) nomatch <= 1'b0;
		fwd(4'h0, 1'b1, 15'h0001, 15'h0001, 1'b0);
		give_verdict();
	end
endmodule
